// ---- common/param_ram_pkg.sv ----
// package: address map, sizes and reset values of the filter and gain parameter memory
package param_ram_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          DEPTH         = 118;
  localparam logic [7:0]  GAIN_BASE     = 8'h80;
  localparam logic [7:0]  GAIN_LAST     = 8'h9f;
  localparam logic [7:0]  FIR1_BASE     = 8'ha0;
  localparam logic [7:0]  FIR1_LAST     = 8'hb5;
  localparam logic [7:0]  FIR2_BASE     = 8'hb6;
  localparam logic [7:0]  FIR2_LAST     = 8'hf5;
  localparam int          GAIN_ENTRIES  = 32;
  localparam int          FIR1_TAPS     = 11;
  localparam int          FIR2_TAPS     = 32;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : param_ram_pkg

// ---- src/filter_gain_parameter_ram.sv ----
// module: byte-wide gain table and fir coefficient memory behind an apb slave
//
// Overview of operation
// - 32 signed gain bytes at 128..159
// - first fir: 11 coefficients at 160..181
// - second fir: 32 coefficients at 182..245
// - low byte at lower address, high next
// - master reset clears every location
// - sync input never alters contents
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module filter_gain_parameter_ram (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        master_reset_n,
  input  wire logic        sync_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [param_ram_pkg::GAIN_ENTRIES*8-1:0] gain_table,
  output logic [param_ram_pkg::FIR1_TAPS*16-1:0]   first_fir_coefficient_ram,
  output logic [param_ram_pkg::FIR2_TAPS*16-1:0]   second_fir_coefficient_ram
);

  // ****************************************************************
  // reset and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [1:0] mst_rst_sync_r;
  logic       mst_rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // master reset pin is asynchronous to sys_clk, so it is synchronised
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_rst_sync_r <= 2'b11;
    end else if (clk_en) begin
      mst_rst_sync_r <= {mst_rst_sync_r[0], master_reset_n};
    end
  end
  assign mst_rst_n = mst_rst_sync_r[1];

  // sync_n deliberately unused: contents are immune to it
  logic unused_sync;
  assign unused_sync = sync_n;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [7:0]  byte_addr;
  logic        in_range;
  logic        wr_hit;
  logic [6:0]  idx;
  logic        access_done;
  logic        loaded_r;
  logic [31:0] prdata_r;

  // one byte location per aligned word: byte address = 4 * location
  assign byte_addr = paddr[9:2];
  // anything outside the three regions answers with an error and reads zero
  assign in_range  = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'b00)
                   && (byte_addr >= param_ram_pkg::GAIN_BASE)
                   && (byte_addr <= param_ram_pkg::FIR2_LAST);
  assign idx       = 7'(byte_addr - param_ram_pkg::GAIN_BASE);
  // ready waits for clk_en and for the read word captured in an earlier cycle
  assign pready      = clk_en && loaded_r;
  assign access_done = psel && penable && pready;
  assign wr_hit      = access_done && pwrite && in_range && pstrb[0];
  assign pslverr     = psel && penable && !in_range;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem_r [param_ram_pkg::DEPTH];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < param_ram_pkg::DEPTH; i++) begin
        mem_r[i] <= param_ram_pkg::BYTE_RESET;
      end
    end else if (clk_en) begin
      // a write that falls in a master reset cycle is lost on purpose
      if (!mst_rst_n) begin
        for (int i = 0; i < param_ram_pkg::DEPTH; i++) begin
          mem_r[i] <= param_ram_pkg::BYTE_RESET;
        end
      end else if (wr_hit) begin
        mem_r[idx] <= pwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // the word is captured one edge before the access phase, so prdata comes
  // from flip-flops at no wait-state cost while clk_en stays high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_r <= 1'b0;
    end else if (clk_en) begin
      if (access_done) begin
        loaded_r <= 1'b0;
      end else if (psel) begin
        loaded_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= param_ram_pkg::UNMAPPED_DATA;
    end else if (clk_en && psel && !access_done) begin
      if (in_range) begin
        prdata_r <= {24'h0, mem_r[idx]};
      end else begin
        prdata_r <= param_ram_pkg::UNMAPPED_DATA;
      end
    end
  end
  assign prdata = prdata_r;

  // ****************************************************************
  // datapath views of the memory
  // ****************************************************************
  localparam int FIR1_OFS = int'(param_ram_pkg::FIR1_BASE) - int'(param_ram_pkg::GAIN_BASE);
  localparam int FIR2_OFS = int'(param_ram_pkg::FIR2_BASE) - int'(param_ram_pkg::GAIN_BASE);

  // views are plain wiring of the flip-flops, so they settle with the memory
  always_comb begin
    for (int g = 0; g < param_ram_pkg::GAIN_ENTRIES; g++) begin
      gain_table[g*8 +: 8] = mem_r[g];
    end
    for (int c = 0; c < param_ram_pkg::FIR1_TAPS; c++) begin
      first_fir_coefficient_ram[c*16 +: 16] =
        {mem_r[FIR1_OFS + 2*c + 1], mem_r[FIR1_OFS + 2*c]};
    end
    for (int c = 0; c < param_ram_pkg::FIR2_TAPS; c++) begin
      second_fir_coefficient_ram[c*16 +: 16] =
        {mem_r[FIR2_OFS + 2*c + 1], mem_r[FIR2_OFS + 2*c]};
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // a completed write must sit in its location at the next edge
  chk_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_hit && mst_rst_n
    |=> mem_r[$past(idx)] == $past(pwdata[7:0]))
    else $error("written byte not stored");
  // captured word must still match the memory when the read completes
  chk_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_done && !pwrite && in_range && mst_rst_n && $past(mst_rst_n)
    |-> prdata == {24'h0, mem_r[idx]})
    else $error("read data differs from stored byte");
  chk_master_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !mst_rst_n
    |=> gain_table == '0 && first_fir_coefficient_ram == '0
      && second_fir_coefficient_ram == '0)
    else $error("master reset left nonzero content");
  chk_sync_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sync_n && !wr_hit && mst_rst_n
    |=> $stable(gain_table) && $stable(first_fir_coefficient_ram)
      && $stable(second_fir_coefficient_ram))
    else $error("sync changed memory");
  chk_fir1_high_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_hit && mst_rst_n && byte_addr == param_ram_pkg::FIR1_BASE + 8'h01
    |=> first_fir_coefficient_ram[15:8] == $past(pwdata[7:0]))
    else $error("first fir high byte misplaced");
  chk_fir2_low_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_hit && mst_rst_n && byte_addr == param_ram_pkg::FIR2_BASE
    |=> second_fir_coefficient_ram[7:0] == $past(pwdata[7:0]))
    else $error("second fir low byte misplaced");
  chk_gain_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && byte_addr == param_ram_pkg::GAIN_LAST
      && paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("gain table end not mapped");
  chk_low_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_done && byte_addr < param_ram_pkg::GAIN_BASE
    |-> pslverr && prdata == param_ram_pkg::UNMAPPED_DATA)
    else $error("address below gain table mapped");
  chk_top_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_done && byte_addr > param_ram_pkg::FIR2_LAST
    |-> pslverr && prdata == param_ram_pkg::UNMAPPED_DATA)
    else $error("address past second fir mapped");
  // a low clock enable holds every stored and read-back value
  chk_enable_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en
    |=> $stable(gain_table) && $stable(first_fir_coefficient_ram)
      && $stable(second_fir_coefficient_ram) && $stable(prdata))
    else $error("state moved while clock enable low");
  chk_strobe_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_done && pwrite && !pstrb[0] && mst_rst_n
    |=> $stable(gain_table) && $stable(first_fir_coefficient_ram)
      && $stable(second_fir_coefficient_ram))
    else $error("write with byte lane off changed memory");

  cov_gain_write: cover property (@(posedge sys_clk)
    wr_hit && byte_addr <= param_ram_pkg::GAIN_LAST);
  cov_fir1_write: cover property (@(posedge sys_clk)
    wr_hit && byte_addr == param_ram_pkg::FIR1_LAST);
  cov_fir2_write: cover property (@(posedge sys_clk)
    wr_hit && byte_addr == param_ram_pkg::FIR2_BASE);
  cov_master_rst: cover property (@(posedge sys_clk) !mst_rst_n ##1 mst_rst_n);
  cov_sync_pulse: cover property (@(posedge sys_clk) !sync_n ##1 sync_n);

endmodule : filter_gain_parameter_ram

// ---- test/filter_gain_parameter_ram_tb_top.sv ----
// testbench: apb byte access to the gain table and fir coefficient memory
`timescale 1ns/100ps
module filter_gain_parameter_ram_tb_top;
  logic        sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic        master_reset_n = 1'b1, sync_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic [3:0]  pstrb = 4'hf;
  logic [255:0] gain_table;
  logic [175:0] fir1;
  logic [511:0] fir2;
  int          n_mismatch = 0, comparisons = 0;
  // location and data; region edges and both coefficient bytes
  logic [7:0]  rows [8][2] = '{'{8'h80, 8'h5a}, '{8'h9f, 8'ha5}, '{8'ha0, 8'h34},
    '{8'ha1, 8'h12}, '{8'hb5, 8'h81}, '{8'hb6, 8'h7e}, '{8'hb7, 8'hc3}, '{8'hf5, 8'h01}};
  always #2 sys_clk = ~sys_clk;
  filter_gain_parameter_ram u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .master_reset_n(master_reset_n), .sync_n(sync_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gain_table(gain_table),
    .first_fir_coefficient_ram(fir1), .second_fir_coefficient_ram(fir2));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp
  // one transfer, entered just after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic wr, input logic [7:0] loc, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, loc, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      cmp("pready", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  function automatic logic [7:0] view(input logic [7:0] loc);
    if (loc < 8'ha0)
      return gain_table[(loc - 128) * 8 +: 8];
    if (loc < 8'hb6)
      return fir1[(loc - 160) * 8 +: 8];
    return fir2[(loc - 182) * 8 +: 8];
  endfunction : view
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    // sync flops need two edges before the first setup
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) apb(1'b1, rows[i][0], rows[i][1], q, e);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][0], 8'h00, q, e);
      cmp("readback", {24'h0, rows[i][1]}, q);
      cmp("readback err", 32'h0, {31'h0, e});
      cmp("view byte", {24'h0, rows[i][1]}, {24'h0, view(rows[i][0])});
    end
    cmp("coef0", 32'h1234, {16'h0, fir1[15:0]});
    cmp("second coef0", 32'hc37e, {16'h0, fir2[15:0]});
    // byte lane 0 off: the write must be dropped
    pstrb <= 4'he;
    apb(1'b1, 8'h80, 8'hff, q, e);
    pstrb <= 4'hf;
    apb(1'b0, 8'h80, 8'h00, q, e);
    cmp("masked write", 32'h5a, q);
    sync_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sync_n <= 1'b1;
    @(posedge sys_clk);
    cmp("sync views", 32'hc37e_1234, {fir2[15:0], fir1[15:0]});
    apb(1'b0, 8'ha1, 8'h00, q, e);
    cmp("after sync", 32'h12, q);
    apb(1'b0, 8'h7f, 8'h00, q, e);
    cmp("unmapped err", 32'h1, {31'h0, e});
    cmp("unmapped data", 32'h0, q);
    apb(1'b1, 8'hf6, 8'h99, q, e);
    cmp("past end err", 32'h1, {31'h0, e});
    apb(1'b0, 8'hf6, 8'h00, q, e);
    cmp("past end data", 32'h0, q);
    apb(1'b0, 8'hf5, 8'h00, q, e);
    cmp("last byte", 32'h01, q);
    // clock enable low: a master reset pulse must not reach the memory
    clk_en <= 1'b0;
    master_reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    master_reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    cmp("frozen view", 32'h5a, {24'h0, gain_table[7:0]});
    master_reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    master_reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp("cleared bus", 32'h0, {31'h0, |{gain_table, fir1, fir2}});
    apb(1'b0, 8'hf5, 8'h00, q, e);
    cmp("cleared", 32'h0, q);
    // second reset in mid-run also clears the contents
    apb(1'b1, 8'h90, 8'h3c, q, e);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp("reset prdata", 32'h0, prdata);
    cmp("reset view", 32'h0, {24'h0, gain_table[16*8 +: 8]});
    apb(1'b0, 8'h90, 8'h00, q, e);
    cmp("reset read", 32'h0, q);
    print_verdict();
  end
endmodule : filter_gain_parameter_ram_tb_top
